// ===== inc/llc_pkg.sv
// package: register map, reset values and timing constants for the led lighting control core
package llc_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NUM_OUT = 9;
  localparam int NUM_PUMPED = 6;
  localparam int NUM_ENG = 3;
  localparam int PROG_DEPTH = 96;
  localparam int PWM_BITS = 12;
  localparam int CUR_BITS = 8;
  localparam int NUM_SLOPES = 31;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
  localparam logic [11:0] OFS_TEMP = 12'h010;
  localparam logic [11:0] OFS_TEST = 12'h014;
  localparam logic [11:0] OFS_ENG_CTRL = 12'h018;
  localparam logic [11:0] OFS_ENG_MAP0 = 12'h01c;
  localparam logic [11:0] OFS_PWM0 = 12'h040;
  localparam logic [11:0] OFS_CUR0 = 12'h080;
  localparam logic [11:0] OFS_PROG0 = 12'h200;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_CP_MODE_LSB = 0;
  localparam int CTRL_PWM_PS = 2;
  localparam int CTRL_TC_ONCE = 3;
  localparam int CTRL_APS_EN = 4;
  localparam int CTRL_SLOPE_LSB = 8;
  localparam int CTRL_FILT_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0008_0010;
  localparam logic [31:0] CUR_RST = 32'h0000_00af;
  // ---------------------------------------------------------------
  // interrupt bits
  // ---------------------------------------------------------------
  localparam int IRQ_TEST_DONE = 0;
  localparam int IRQ_GAIN_CHG = 1;
  localparam int IRQ_PSAVE = 2;
  localparam int IRQ_ENG0 = 3;
  localparam int IRQ_BITS = 6;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BYPASS_MS = 50;
  localparam int BYPASS_CYC = BYPASS_MS * (CLK_HZ / 1000);
  localparam int TEST_CYC = 16;
  localparam int PUMP_HALF_CYC = 16;
  localparam int PWM_STEP_CYC = 20;
  // ---------------------------------------------------------------
  // pump modes and test channels
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CP_OFF = 2'b00,
    CP_BYPASS = 2'b01,
    CP_BOOST = 2'b10,
    CP_AUTO = 2'b11
  } llc_cp_mode_t;
  localparam logic [3:0] TSEL_SUPPLY = 4'h9;
  localparam logic [3:0] TSEL_RAIL = 4'ha;
  localparam logic [3:0] TSEL_IRQPIN = 4'hb;
endpackage

// ===== rtl/llc_core.sv
// led lighting control core: engines, pwm, test, power save, temperature compensation, pump control
//
// Overview of operation
// (RULE1) three independent program engines
// (RULE2) engine groups map one to nine outputs
// (RULE3) shared 96-word program store
// (RULE4) eight-bit current setting per output
// (RULE5) twelve-bit pwm, compensation through pwm
// (RULE6) direct control or engine patterns
// (RULE7) bus write starts test, result readable
// (RULE8) test also measures supply, rail, irq pin
// (RULE9) only six pumped outputs steer gain
// (RULE10) auto power save when outputs idle
// (RULE11) pwm power save during off time
// (RULE12) linear temperature slope, 31 choices
// (RULE13) compensation continuous or once after wake
// (RULE14) pump gain 1x or 1.5x
// (RULE15) two-phase non-overlapping pump clock
// (RULE16) auto gain up on low headroom
// (RULE17) bypass after 50 ms idle
// (RULE18) engine overrides direct pwm
// (RULE19) gain decisions digitally filtered
`timescale 1ns/1ns
module llc_core
  import llc_pkg::*;
#(
  parameter int BYPASS_CYCLES = BYPASS_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side inputs, asynchronous
  input wire logic [NUM_PUMPED-1:0] headroom_low,
  input wire logic [7:0] temp_code,
  input wire logic [7:0] adc_result,
  // driver outputs
  output logic [NUM_OUT-1:0] drv_on,
  output logic [NUM_OUT*CUR_BITS-1:0] drv_current,
  // pump, power, test and interrupt
  output logic pump_boost,
  output logic pump_enable,
  output logic pump_ph_charge,
  output logic pump_ph_pump,
  output logic power_save,
  output logic [3:0] adc_sel,
  output logic adc_start,
  output logic irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_ff; // pump mode, power save, slope, filter length
  logic [PWM_BITS-1:0] pwm_ff [NUM_OUT]; // direct duty per output
  logic [CUR_BITS-1:0] cur_ff [NUM_OUT]; // current setting per output
  logic [31:0] prog_ff [PROG_DEPTH]; // shared program store
  logic [NUM_OUT-1:0] map_ff [NUM_ENG]; // outputs owned by each engine
  logic [NUM_ENG-1:0] eng_run_ff; // engine run bits
  logic [6:0] eng_pc_ff [NUM_ENG]; // engine program counter
  logic [6:0] eng_start_ff [NUM_ENG]; // engine start address
  logic [PWM_BITS-1:0] eng_pwm_ff [NUM_ENG]; // engine output duty
  logic [15:0] eng_wait_ff [NUM_ENG]; // engine wait counter
  logic [IRQ_BITS-1:0] irq_stat_ff, irq_mask_ff;
  logic [3:0] tsel_ff; // test channel
  logic test_busy_ff;
  logic [4:0] test_cnt_ff;
  logic [7:0] test_res_ff;
  logic [1:0] hr_s1_ff [NUM_PUMPED];
  logic [NUM_PUMPED-1:0] hr_sync_ff;
  logic [7:0] temp_s1_ff, temp_ff, adc_s1_ff, adc_ff;
  // ---------------------------------------------------------------
  // apb access
  // ---------------------------------------------------------------
  wire acc = psel & penable & pready & clk_en;
  wire wr = acc & pwrite;
  // index decoding reused by writes and reads
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base, input int n);
    in_win = (a >= base) && (a < base + 12'(n * 4));
  endfunction
  wire [6:0] widx = paddr[8:2];
  wire [3:0] oidx = paddr[5:2];

  // control register and direct settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      tsel_ff <= 4'h0;
      eng_run_ff <= '0;
      for (int i = 0; i < NUM_OUT; i++) begin
        pwm_ff[i] <= '0;
        cur_ff[i] <= CUR_RST[CUR_BITS-1:0];
      end
      for (int e = 0; e < NUM_ENG; e++) begin
        map_ff[e] <= '0;
        eng_start_ff[e] <= '0;
      end
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_ff <= pwdata;
      if (paddr == OFS_ENG_CTRL) begin
        eng_run_ff <= pwdata[NUM_ENG-1:0]; // (RULE1)
        for (int e = 0; e < NUM_ENG; e++) eng_start_ff[e] <= pwdata[8+8*e +: 7]; // (RULE3)
      end
      for (int e = 0; e < NUM_ENG; e++)
        if (paddr == OFS_ENG_MAP0 + 12'(4 * e)) map_ff[e] <= pwdata[NUM_OUT-1:0]; // (RULE2)
      if (in_win(paddr, OFS_PWM0, NUM_OUT)) pwm_ff[oidx] <= pwdata[PWM_BITS-1:0]; // (RULE6)
      if (in_win(paddr, OFS_CUR0, NUM_OUT)) cur_ff[oidx] <= pwdata[CUR_BITS-1:0]; // (RULE4)
      if (paddr == OFS_TEST) tsel_ff <= pwdata[3:0];
    end
  end

  // program store, flip-flops indexed by word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PROG_DEPTH; i++) prog_ff[i] <= '0;
    end else if (wr && in_win(paddr, OFS_PROG0, PROG_DEPTH)) begin
      prog_ff[widx] <= pwdata; // (RULE3)
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PUMPED; i++) hr_s1_ff[i] <= '0;
      hr_sync_ff <= '0;
      temp_s1_ff <= '0;
      temp_ff <= '0;
      adc_s1_ff <= '0;
      adc_ff <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_PUMPED; i++) begin
        hr_s1_ff[i] <= {hr_s1_ff[i][0], headroom_low[i]};
        hr_sync_ff[i] <= hr_s1_ff[i][1];
      end
      temp_s1_ff <= temp_code;
      temp_ff <= temp_s1_ff;
      adc_s1_ff <= adc_result;
      adc_ff <= adc_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // program engines: word = {op[31:30], duty[27:16], arg[15:0]}
  // op 0 set duty and wait arg, 1 jump to arg, 2 end, 3 end with irq
  // ---------------------------------------------------------------
  logic [NUM_ENG-1:0] eng_done;
  genvar g;
  generate
    for (g = 0; g < NUM_ENG; g++) begin : g_eng
      wire [31:0] ins = prog_ff[eng_pc_ff[g]];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          eng_pc_ff[g] <= '0;
          eng_pwm_ff[g] <= '0;
          eng_wait_ff[g] <= '0;
        end else if (clk_en) begin
          if (!eng_run_ff[g]) begin
            eng_pc_ff[g] <= eng_start_ff[g]; // each engine runs on its own pc (RULE1)
            eng_wait_ff[g] <= '0;
          end else if (eng_wait_ff[g] != 16'h0000) begin
            eng_wait_ff[g] <= eng_wait_ff[g] - 16'h0001;
          end else begin
            unique case (ins[31:30])
              2'b00: begin
                eng_pwm_ff[g] <= ins[27:16];
                eng_wait_ff[g] <= ins[15:0];
                eng_pc_ff[g] <= (eng_pc_ff[g] == 7'(PROG_DEPTH - 1)) ? 7'h00 : eng_pc_ff[g] + 7'h01;
              end
              2'b01: eng_pc_ff[g] <= (ins[6:0] < 7'(PROG_DEPTH)) ? ins[6:0] : 7'h00;
              default: ;
            endcase
          end
        end
      end
      assign eng_done[g] = eng_run_ff[g] && eng_wait_ff[g] == 16'h0000 && ins[31:30] == 2'b11;
    end
  endgenerate

  // ---------------------------------------------------------------
  // effective duty, temperature compensation, pwm
  // ---------------------------------------------------------------
  logic [PWM_BITS-1:0] pwm_cnt_ff;
  logic [4:0] step_ff;
  logic [7:0] temp_hold_ff; // temperature used by compensation
  logic [NUM_OUT-1:0] drv_on_ff;
  logic psave_ff;
  logic [PWM_BITS-1:0] duty [NUM_OUT];
  wire [4:0] slope = ctrl_ff[CTRL_SLOPE_LSB +: 5];
  // signed temperature offset from mid code times slope, 31 slopes plus off
  wire signed [8:0] tdelta = $signed({1'b0, temp_hold_ff}) - 9'sd128;
  wire signed [14:0] tcomp = 15'(tdelta * $signed({1'b0, slope})); // (RULE12)

  always_comb begin
    logic [PWM_BITS-1:0] base;
    logic signed [14:0] adj;
    base = '0;
    adj = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      base = pwm_ff[i];
      for (int e = NUM_ENG - 1; e >= 0; e--)
        if (eng_run_ff[e] && map_ff[e][i]) base = eng_pwm_ff[e]; // (RULE18)
      adj = $signed({3'b000, base}) - (slope == 5'h00 ? 15'sd0 : tcomp); // (RULE5)
      if (base == '0) duty[i] = '0;
      else if (adj < 15'sd0) duty[i] = '0;
      else if (adj > 15'sd4095) duty[i] = '1;
      else duty[i] = adj[PWM_BITS-1:0];
    end
  end

  logic active;
  always_comb begin
    active = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) active = active | (duty[i] != '0);
  end

  // pwm counter and driver outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_ff <= '0;
      step_ff <= '0;
      drv_on_ff <= '0;
    end else if (clk_en) begin
      step_ff <= (step_ff == 5'(PWM_STEP_CYC - 1)) ? 5'h00 : step_ff + 5'h01;
      if (step_ff == 5'(PWM_STEP_CYC - 1)) pwm_cnt_ff <= pwm_cnt_ff + 12'h001; // (RULE5)
      for (int i = 0; i < NUM_OUT; i++) drv_on_ff[i] <= (pwm_cnt_ff < duty[i]);
    end
  end

  // temperature sample: continuous or latched once at wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) temp_hold_ff <= 8'h80;
    else if (clk_en) begin
      if (!ctrl_ff[CTRL_TC_ONCE] || (psave_ff && active)) temp_hold_ff <= temp_ff; // (RULE13)
    end
  end

  // automatic power save
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) psave_ff <= 1'b0;
    else if (clk_en) psave_ff <= ctrl_ff[CTRL_APS_EN] & ~active; // (RULE10)
  end

  // ---------------------------------------------------------------
  // pump gain control
  // ---------------------------------------------------------------
  logic boost_ff, pump_en_ff, gain_chg;
  logic [15:0] filt_ff;
  logic [$clog2(BYPASS_CYCLES+1)-1:0] idle_ff;
  wire [1:0] cp_mode = ctrl_ff[CTRL_CP_MODE_LSB +: 2];
  wire [15:0] filt_len = {8'h00, ctrl_ff[CTRL_FILT_LSB +: 8]};
  wire need_boost = |(hr_sync_ff & drv_on_ff[NUM_PUMPED-1:0]); // (RULE9)
  wire idle_done = idle_ff == $bits(idle_ff)'(BYPASS_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_ff <= 1'b0;
      filt_ff <= '0;
      idle_ff <= '0;
      gain_chg <= 1'b0;
    end else if (clk_en) begin
      gain_chg <= 1'b0;
      idle_ff <= active ? '0 : (idle_done ? idle_ff : idle_ff + 1'b1);
      unique case (cp_mode)
        CP_OFF, CP_BYPASS: boost_ff <= 1'b0; // (RULE14)
        CP_BOOST: boost_ff <= 1'b1;
        CP_AUTO: begin
          if (idle_done) begin
            gain_chg <= boost_ff;
            boost_ff <= 1'b0; // (RULE17)
            filt_ff <= '0;
          end else if (need_boost != boost_ff) begin
            if (filt_ff >= filt_len) begin
              boost_ff <= need_boost; // (RULE16)
              gain_chg <= 1'b1;
              filt_ff <= '0;
            end else filt_ff <= filt_ff + 16'h0001; // (RULE19)
          end else filt_ff <= '0;
        end
      endcase
    end
  end

  // two-phase pump clock with a dead cycle between phases
  logic [4:0] ph_cnt_ff;
  logic [1:0] ph_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_cnt_ff <= '0;
      ph_ff <= 2'b00;
      pump_en_ff <= 1'b0;
    end else if (clk_en) begin
      pump_en_ff <= (cp_mode != CP_OFF) & ~psave_ff;
      ph_cnt_ff <= (ph_cnt_ff == 5'(PUMP_HALF_CYC - 1)) ? 5'h00 : ph_cnt_ff + 5'h01;
      if (ph_cnt_ff == 5'(PUMP_HALF_CYC - 1)) ph_ff <= 2'b00; // break before make (RULE15)
      else if (ph_cnt_ff == 5'h00 && boost_ff && pump_en_ff) ph_ff <= {pump_ph_charge, ~pump_ph_charge};
    end
  end

  // ---------------------------------------------------------------
  // led test measurement
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_busy_ff <= 1'b0;
      test_cnt_ff <= '0;
      test_res_ff <= '0;
    end else if (clk_en) begin
      if (wr && paddr == OFS_TEST && !test_busy_ff) begin
        test_busy_ff <= 1'b1; // (RULE7)
        test_cnt_ff <= 5'(TEST_CYC);
      end else if (test_busy_ff) begin
        test_cnt_ff <= test_cnt_ff - 5'h01;
        if (test_cnt_ff == 5'h01) begin
          test_busy_ff <= 1'b0;
          test_res_ff <= adc_ff;
        end
      end
    end
  end
  wire test_done = test_busy_ff && test_cnt_ff == 5'h01;

  // ---------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ---------------------------------------------------------------
  wire [IRQ_BITS-1:0] irq_set = {eng_done, psave_ff & active, gain_chg, test_done};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else if (clk_en) begin
      irq_stat_ff <= (irq_stat_ff & ~((wr && paddr == OFS_IRQ_STAT) ? pwdata[IRQ_BITS-1:0] : '0)) | irq_set;
      if (wr && paddr == OFS_IRQ_MASK) irq_mask_ff <= pwdata[IRQ_BITS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // read mux and output flops
  // ---------------------------------------------------------------
  logic [31:0] rd;
  logic hit;
  always_comb begin
    rd = '0;
    hit = 1'b1;
    if (paddr == OFS_CTRL) rd = ctrl_ff;
    else if (paddr == OFS_STATUS) rd = {24'h0, eng_run_ff, test_busy_ff, psave_ff, pump_en_ff, boost_ff, active};
    else if (paddr == OFS_IRQ_STAT) rd = {26'h0, irq_stat_ff};
    else if (paddr == OFS_IRQ_MASK) rd = {26'h0, irq_mask_ff};
    else if (paddr == OFS_TEMP) rd = {24'h0, temp_ff};
    else if (paddr == OFS_TEST) rd = {20'h0, tsel_ff, test_res_ff}; // (RULE7)
    else if (paddr == OFS_ENG_CTRL) rd = {1'b0, eng_start_ff[2], 1'b0, eng_start_ff[1], 1'b0, eng_start_ff[0], 5'h0, eng_run_ff};
    else if (in_win(paddr, OFS_ENG_MAP0, NUM_ENG)) rd = {23'h0, map_ff[paddr[3:2] - 2'h3]};
    else if (in_win(paddr, OFS_PWM0, NUM_OUT)) rd = {20'h0, pwm_ff[oidx]};
    else if (in_win(paddr, OFS_CUR0, NUM_OUT)) rd = {24'h0, cur_ff[oidx]};
    else if (in_win(paddr, OFS_PROG0, PROG_DEPTH)) rd = prog_ff[widx];
    else hit = 1'b0;
  end

  logic [NUM_OUT*CUR_BITS-1:0] cur_flat;
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) cur_flat[i*CUR_BITS +: CUR_BITS] = cur_ff[i];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      drv_on <= '0;
      drv_current <= '0;
      pump_boost <= 1'b0;
      pump_enable <= 1'b0;
      pump_ph_charge <= 1'b0;
      pump_ph_pump <= 1'b0;
      power_save <= 1'b0;
      adc_sel <= '0;
      adc_start <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~pready;
      pslverr <= psel & ~pready & ~hit;
      prdata <= (psel & ~pwrite & hit) ? rd : 32'h0;
      // pwm power save leaves the drivers alone and drops the pump enable while all drivers are in the low part
      drv_on <= drv_on_ff;
      drv_current <= cur_flat;
      pump_boost <= boost_ff;
      pump_enable <= pump_en_ff & ~(ctrl_ff[CTRL_PWM_PS] & ~|drv_on_ff); // (RULE11)
      pump_ph_charge <= ph_ff[0];
      pump_ph_pump <= ph_ff[1];
      power_save <= psave_ff;
      adc_sel <= tsel_ff; // includes supply, rail and irq pin channels (RULE8)
      adc_start <= wr && paddr == OFS_TEST && !test_busy_ff;
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end
endmodule

// ===== sim/llc_core_assertions.sv
// checker: port assertions for the led lighting control core
`timescale 1ns/1ns
module llc_chk
  import llc_pkg::*;
#(
  parameter int BYPASS_CYCLES = BYPASS_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // pump, test and power
  input wire logic pump_ph_charge,
  input wire logic pump_ph_pump,
  input wire logic adc_start,
  input wire logic power_save,
  input wire logic [NUM_OUT-1:0] drv_on
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic test_wr; // accepted write to the test launch word
  assign test_wr = psel && penable && pready && pwrite && (paddr == OFS_TEST);
  // setup cycle of a fresh transfer
  sequence apb_setup;
    psel && !penable && !pready;
  endsequence
  // start of a charge phase
  sequence charge_start;
    $rose(pump_ph_charge);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  answer_time_a: assert property (apb_setup |=> pready)
    else $error("no answer in the access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  error_qual_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  test_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("test launch pulse too long");
  test_cause_a: assert property (adc_start |-> $past(test_wr) || $past(test_wr, 2))
    else $error("test launched without a bus write");
  phase_excl_a: assert property (!(pump_ph_charge && pump_ph_pump))
    else $error("pump phases overlap");
  phase_hold_a: assert property (charge_start |-> pump_ph_charge [*8])
    else $error("charge phase cut short");
  save_dark_a: assert property (power_save |-> drv_on == '0)
    else $error("output active in power save");
endmodule

bind llc_core llc_chk #(.BYPASS_CYCLES(BYPASS_CYCLES)) i_llc_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pump_ph_charge(pump_ph_charge), .pump_ph_pump(pump_ph_pump), .adc_start(adc_start),
  .power_save(power_save), .drv_on(drv_on));

// ===== sim/llc_host.sv
// host processor model: register bus master for the core
`timescale 1ns/1ns
module llc_host (
  // clock
  input wire logic pclk,
  // bus master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hang = 0; // transfers that never got an answer
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ----------------------------------------
  // one transfer, held until ready is seen or 64 cycles pass
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 64) hang++;
    q = prdata;
    e = pslverr;
    // released lines carry no stale value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== sim/test_led_lighting_control_core.sv
// testbench for the led lighting control core
`timescale 1ns/1ns
module test_led_lighting_control_core;
  import llc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1; // tied: freezing is not exercised
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [5:0] headroom_low = 6'h00;
  logic [7:0] temp_code = 8'h80;
  logic [7:0] adc_result = 8'h00;
  logic [8:0] drv_on;
  logic [71:0] drv_current;
  logic pump_boost, pump_enable, ph_c, ph_p, power_save, adc_start, irq;
  logic [3:0] adc_sel;
  wire [3:0] mon = {irq, adc_start, power_save, pump_boost}; // watched flags
  int mismatches = 0;
  int total_checks = 0;
  always #20 pclk = ~pclk;
  llc_core #(.BYPASS_CYCLES(100)) i_llc_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .headroom_low(headroom_low), .temp_code(temp_code),
    .adc_result(adc_result), .drv_on(drv_on), .drv_current(drv_current), .pump_boost(pump_boost),
    .pump_enable(pump_enable), .pump_ph_charge(ph_c), .pump_ph_pump(ph_p), .power_save(power_save),
    .adc_sel(adc_sel), .adc_start(adc_start), .irq(irq));
  llc_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(logic w, logic [11:0] a, logic [31:0] d);
    host.xfer(w, a, d, q, e);
    if (host.hang != 0) begin
      chk("bus answer", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  // bounded wait for a watched flag; a miss ends the run
  task mon_wait(int k, logic v, int lim, string what);
    for (int n = 0; n < lim && mon[k] !== v; n++) @(posedge pclk);
    chk(what, {31'h0, v}, {31'h0, mon[k]});
    if (mon[k] !== v) end_of_test();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RST, q);
    bus(1'b0, OFS_CUR0, 32'h0);
    chk("cur reset", CUR_RST, q);
    chk("cur out", {24'h0, CUR_RST[7:0]}, {24'h0, drv_current[7:0]});
    bus(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    mon_wait(1, 1'b1, 300, "save idle");
    $display("reset test done");
  endtask
  task t_regs;
    bus(1'b1, OFS_CUR0 + 12'h004, 32'h5a);
    bus(1'b0, OFS_CUR0 + 12'h004, 32'h0);
    chk("cur1", 32'h5a, q);
    chk("cur1 out", 32'h5a, {24'h0, drv_current[15:8]});
    bus(1'b1, OFS_PWM0, 32'hfff);
    bus(1'b0, OFS_PWM0, 32'h0);
    chk("pwm0", 32'hfff, q);
    mon_wait(1, 1'b0, 300, "save wake");
    chk("drv on", 32'h1, {31'h0, drv_on[0]});
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_ENG_MAP0 + 12'(4 * i), 32'h1ff);
      bus(1'b0, OFS_ENG_MAP0 + 12'(4 * i), 32'h0);
      chk("eng map", 32'h1ff, q);
    end
    bus(1'b1, OFS_PROG0 + 12'h17c, 32'h8000_0000);
    bus(1'b0, OFS_PROG0 + 12'h17c, 32'h0);
    chk("prog last", 32'h8000_0000, q);
    bus(1'b0, OFS_PROG0 + 12'h180, 32'h0);
    chk("prog end", 32'h1, {31'h0, e});
    bus(1'b1, OFS_PROG0, 32'hc000_0000);
    bus(1'b1, OFS_ENG_CTRL, 32'h1);
    mon_wait(1, 1'b1, 40, "eng override");
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("eng end", 32'h8, q & 32'h8);
    bus(1'b1, OFS_ENG_CTRL, 32'h0);
    $display("register test done");
  endtask
  task automatic t_test;
    logic [3:0] ch[4] = '{4'h0, TSEL_SUPPLY, TSEL_RAIL, TSEL_IRQPIN};
    for (int i = 0; i < 4; i++) begin
      adc_result <= 8'h30 + 8'(i);
      bus(1'b1, OFS_TEST, {28'h0, ch[i]});
      mon_wait(2, 1'b1, 8, "test start");
      @(posedge pclk);
      chk("test channel", {28'h0, ch[i]}, {28'h0, adc_sel});
      repeat (TEST_CYC + 4) @(posedge pclk);
      bus(1'b0, OFS_TEST, 32'h0);
      chk("test result", 32'h30 + 32'(i), q & 32'hff);
    end
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("done flag", 32'h1, q & 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    mon_wait(3, 1'b1, 8, "irq raise");
    bus(1'b1, OFS_IRQ_STAT, 32'h1);
    mon_wait(3, 1'b0, 8, "irq clear");
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("done clear", 32'h0, q & 32'h1);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    $display("led test done");
  endtask
  task automatic t_pump;
    logic [31:0] ct = CTRL_RST & 32'hffff_fffc;
    logic bad = 1'b0;
    bus(1'b1, OFS_CTRL, ct | 32'h2);
    mon_wait(0, 1'b1, 200, "boost mode");
    chk("pump on", 32'h1, {31'h0, pump_enable});
    bus(1'b1, OFS_CTRL, ct | 32'h1);
    mon_wait(0, 1'b0, 200, "bypass mode");
    bus(1'b1, OFS_CTRL, ct | 32'h3);
    // a short headroom dip must not move the gain
    @(posedge pclk);
    headroom_low <= 6'h01;
    repeat (2) @(posedge pclk);
    headroom_low <= 6'h00;
    repeat (60) begin
      @(posedge pclk);
      bad = bad | pump_boost;
    end
    chk("glitch", 32'h0, {31'h0, bad});
    headroom_low <= 6'h21;
    mon_wait(0, 1'b1, 600, "gain up");
    headroom_low <= 6'h00;
    mon_wait(0, 1'b0, 600, "gain down");
    headroom_low <= 6'h01;
    mon_wait(0, 1'b1, 600, "gain up first");
    bus(1'b1, OFS_CTRL, ct | 32'h00ff_0003);
    bus(1'b1, OFS_PWM0, 32'h0);
    mon_wait(0, 1'b0, 150, "idle bypass");
    mon_wait(1, 1'b1, 400, "save again");
    $display("pump test done");
  endtask
  // ----------------------------------------
  // main sequence and overall limit
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_test();
    t_pump();
    end_of_test();
  end
  initial begin
    #3_600_000;
    chk("run time", 32'h0, 32'h1);
    end_of_test();
  end
endmodule
